// *** dv/bus_wake_payload_filter_test.sv ***
// Testbench for the bus wake payload filter
`timescale 1ns/1ps
`default_nettype none
`include "bwpf_regs.svh"
module bus_wake_payload_filter_test;
    import bwpf_pkg::*;
    logic          clock, nrst, psel, penable, pwrite, ignition, en, rdErr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdData;
    logic          pready, pslverr, rxValid, rxExtended, wakePulse;
    logic          loggerRun, stopRequest, timeoutAlert, logEntry;
    bwpf_ident_t   rxIdent;
    bwpf_payload_t rxPayload, pv, pm;
    int            badCount, totalChecks, n;
    bwpf_filter dut (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxValid(rxValid), .rxExtended(rxExtended), .rxIdent(rxIdent),
        .rxPayload(rxPayload), .ignition(ignition), .wakePulse(wakePulse),
        .loggerRun(loggerRun), .stopRequest(stopRequest),
        .timeoutAlert(timeoutAlert), .logEntry(logEntry));
    bwpf_can_node node (.clock(clock), .rxValid(rxValid),
        .rxExtended(rxExtended), .rxIdent(rxIdent), .rxPayload(rxPayload));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic endSim;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t word %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmpBit(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t flag %b want %b", $time, got, exp);
        end
    endtask
    // Master holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            cmpBit(1'b0, 1'b1);
            endSim();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected wake worked out from the configured id 22, id mask 28
    task automatic frame(input logic ext, input bwpf_ident_t id,
                         input bwpf_payload_t pay);
        logic exp;
        exp = en && !ext && ((id ^ 29'd22) & 29'd28) == 0
              && ((pay ^ pv) & pm) == 0;
        node.send(ext, id, pay);
        #1;
        cmpBit(wakePulse, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, psel, penable, pwrite, ignition, en} = '0;
        paddr = '0;
        pwdata = '0;
        {badCount, totalChecks} = '0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        apb(0, `BWPF_OFF_STATUS, 32'h0000_0000);
        cmp32(rdData, `BWPF_WORD_RST);
        apb(0, `BWPF_OFF_TIMEOUT, 32'h0000_0000);
        cmp32(rdData, `BWPF_TIMEOUT_RST);
        apb(0, 12'h040, 32'h0000_0000);
        cmpBit(rdErr, 1'b1);
        cmp32(rdData, 32'h0000_0000);
        $display("test reset done");
        pv = 64'h8000_0000_0000_0010;
        pm = 64'h8000_0000_0000_0018;
        apb(1, `BWPF_OFF_TIMEOUT, 32'h0000_03E8);
        apb(1, `BWPF_OFF_ID_VALUE, 32'h0000_0016);
        apb(1, `BWPF_OFF_ID_MASK, 32'h0000_001C);
        apb(1, `BWPF_OFF_DATA_LO, 32'h0000_0010);
        apb(1, `BWPF_OFF_MASK_LO, 32'h0000_0018);
        apb(1, `BWPF_OFF_DATA_HI, 32'h8000_0000);
        apb(1, `BWPF_OFF_MASK_HI, 32'h8000_0000);
        frame(0, 29'd277, 64'h8000_0000_0000_0011);
        apb(1, `BWPF_OFF_CTRL, 32'h0000_0001);
        en = 1'b1;
        frame(0, 29'd277, 64'h8000_0000_0000_0011);
        frame(0, 29'd281, 64'h8000_0000_0000_0011);
        frame(1, 29'd277, 64'h8000_0000_0000_0011);
        frame(0, 29'd277, 64'h8000_0000_0000_0019);
        frame(0, 29'd277, 64'h0000_0000_0000_0011);
        frame(0, 29'd1044, 64'hFFFF_FFFF_FFFF_FFF7);
        apb(1, `BWPF_OFF_MASK_LO, 32'h0000_0000);
        apb(1, `BWPF_OFF_MASK_HI, 32'h0000_0000);
        pm = '0;
        frame(0, 29'd20, 64'h0123_4567_89AB_CDEF);
        frame(0, 29'd281, 64'h0123_4567_89AB_CDEF);
        $display("test compare done");
        apb(1, `BWPF_OFF_TIMEOUT, 32'h0000_0014);
        repeat (40) @(posedge clock);
        frame(0, 29'd20, 64'h0000_0000_0000_0000);
        n = 0;
        while (stopRequest !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        cmpBit(n >= 19 && n <= 22, 1'b1);
        cmpBit(logEntry, 1'b1);
        cmpBit(loggerRun, 1'b0);
        apb(0, `BWPF_OFF_STATUS, 32'h0000_0000);
        cmp32(rdData & 32'h0000_000F, 32'h0000_0002);
        apb(0, `BWPF_OFF_EVCOUNT, 32'h0000_0000);
        cmp32(rdData, 32'h0000_0002);
        apb(1, `BWPF_OFF_CTRL, 32'h0000_0005);
        #1;
        cmpBit(timeoutAlert, 1'b0);
        $display("test timeout done");
        @(posedge clock);
        ignition <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        cmpBit(loggerRun, 1'b1);
        repeat (40) @(posedge clock);
        ignition <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        cmpBit(loggerRun, 1'b0);
        cmpBit(timeoutAlert, 1'b0);
        $display("test ignition done");
        endSim();
    end
endmodule
bind bwpf_filter bwpf_chk chk (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .rxValid(rxValid), .ignition(ignition),
    .pready(pready), .pslverr(pslverr), .wakePulse(wakePulse),
    .loggerRun(loggerRun), .stopRequest(stopRequest),
    .timeoutAlert(timeoutAlert), .logEntry(logEntry));
`default_nettype wire

// *** dv/bwpf_can_node.sv ***
// Model of the other CAN nodes, delivering one received frame at a time
`timescale 1ns/1ps
`default_nettype none
module bwpf_can_node
    import bwpf_pkg::*;
(
    // Clock
    input  wire logic                    clock,
    // Received frame
    output var  logic                    rxValid,
    output var  logic                    rxExtended,
    output var  bwpf_pkg::bwpf_ident_t   rxIdent,
    output var  bwpf_pkg::bwpf_payload_t rxPayload
);
    import bwpf_pkg::*;
    initial begin
        rxValid = 1'b0;
        rxExtended = 1'b0;
        rxIdent = '1;
        rxPayload = '1;
    end
    // Fields are inverted between frames so stale data can never match
    task automatic send(input logic ext, input bwpf_ident_t id,
                        input bwpf_payload_t pay);
        @(posedge clock);
        rxValid <= 1'b1;
        rxExtended <= ext;
        rxIdent <= id;
        rxPayload <= pay;
        @(posedge clock);
        rxValid <= 1'b0;
        rxExtended <= ~ext;
        rxIdent <= ~id;
        rxPayload <= ~pay;
    endtask
endmodule
`default_nettype wire

// *** dv/bwpf_chk.sv ***
// Port checker for the bus wake payload filter
`timescale 1ns/1ps
`default_nettype none
module bwpf_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Bus, frame and ignition inputs
    input wire logic psel,
    input wire logic penable,
    input wire logic rxValid,
    input wire logic ignition,
    // Design outputs
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wakePulse,
    input wire logic loggerRun,
    input wire logic stopRequest,
    input wire logic timeoutAlert,
    input wire logic logEntry
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence setupSeq;
        psel && !penable;
    endsequence
    sequence answerSeq;
        pready ##1 !pready;
    endsequence
    a_ready_one_cycle: assert property (setupSeq |=> answerSeq)
        else $error("pready not one cycle after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pulse_has_frame: assert property (wakePulse |-> $past(rxValid))
        else $error("wake pulse without a frame");
    a_pulse_runs_logger: assert property (wakePulse |-> loggerRun)
        else $error("wake pulse while logger idle");
    a_stop_on_fall: assert property (stopRequest |-> $past(loggerRun) && !loggerRun)
        else $error("stop pulse not at run fall");
    a_log_with_stop: assert property (logEntry |-> stopRequest && timeoutAlert)
        else $error("log entry without stop and alert");
    a_alert_rise_logs: assert property ($rose(timeoutAlert) |-> logEntry)
        else $error("alert raised without log entry");
    a_ign_keeps_run: assert property (ignition [*4] |=> loggerRun && !stopRequest)
        else $error("ignition did not keep logger running");
endmodule
`default_nettype wire

// *** hdl/bwpf_filter.sv ***
// Bus wake payload filter with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "bwpf_regs.svh"

module bwpf_filter
    import bwpf_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               nrst,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    // Received frame from the CAN controller, same clock
    input  wire logic               rxValid,
    input  wire logic               rxExtended,
    input  wire bwpf_pkg::bwpf_ident_t   rxIdent,
    input  wire bwpf_pkg::bwpf_payload_t rxPayload,
    // Ignition pin, asynchronous
    input  wire logic               ignition,
    // Wake outputs
    output var  logic               wakePulse,
    output var  logic               loggerRun,
    output var  logic               stopRequest,
    output var  logic               timeoutAlert,
    output var  logic               logEntry
);
    import bwpf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Compare helper, shared by identifier and payload paths
    function automatic logic masked_eq(input logic [63:0] rx,
                                       input logic [63:0] val,
                                       input logic [63:0] msk);
        masked_eq = ((rx ^ val) & msk) == 64'h0000_0000_0000_0000;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0]   ctrl_reg;
    logic [31:0]   idValue_reg;
    logic [31:0]   idMask_reg;
    bwpf_payload_t dataValue_reg;
    bwpf_payload_t dataMask_reg;
    logic [31:0]   timeout_reg;
    logic [31:0]   evCount_reg;
    logic [31:0]   idleCount_reg;
    logic          alert_reg;
    logic          ignMeta_reg;
    logic          ignSync_reg;
    bwpf_state_e   state_reg;
    bwpf_state_e   state_next;
    logic          payOk_reg;

    ////////////////////////////////////////////////////////////////////
    // Frame match
    wire logic enable  = ctrl_reg[`BWPF_CTRL_ENABLE];
    wire logic extMode = ctrl_reg[`BWPF_CTRL_EXT];
    // Standard frames compare only 11 identifier bits
    wire logic [28:0] idMaskEff = extMode ? idMask_reg[28:0]
                                          : {18'h0_0000, idMask_reg[10:0]};
    wire logic typeOk  = (rxExtended == extMode);
    wire logic idOk    = masked_eq({35'h0, rxIdent},
                                   {35'h0, idValue_reg[28:0]},
                                   {35'h0, idMaskEff});
    // Bit 0 of rxPayload is the first bit sent on the wire
    wire logic payOk   = masked_eq(rxPayload, dataValue_reg,
                                   dataMask_reg);
    wire logic match   = rxValid & enable & typeOk & idOk & payOk;

    ////////////////////////////////////////////////////////////////////
    // Inactivity timer
    wire logic idleDone = (idleCount_reg >= timeout_reg);
    wire logic [31:0] idleInc = idleDone ? idleCount_reg
                                         : idleCount_reg + 32'h0000_0001;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BWPF_ASLEEP: begin
                if (ignSync_reg) begin
                    state_next = BWPF_IGN_AWAKE;
                end else if (match) begin
                    state_next = BWPF_BUS_AWAKE;
                end
            end
            BWPF_BUS_AWAKE: begin
                if (ignSync_reg) begin
                    state_next = BWPF_IGN_AWAKE;
                end else if (!match && idleDone) begin
                    state_next = BWPF_ASLEEP;
                end
            end
            BWPF_IGN_AWAKE: begin
                // Matching traffic still holds the logger after ignition
                if (!ignSync_reg) begin
                    state_next = (match || !idleDone) ? BWPF_BUS_AWAKE
                                                      : BWPF_ASLEEP;
                end
            end
            default: begin
                state_next = BWPF_ASLEEP;
            end
        endcase
    end

    wire logic goSleep = (state_reg != BWPF_ASLEEP)
                       & (state_next == BWPF_ASLEEP);
    // Alert only when bus traffic, not ignition, was keeping us awake
    wire logic timeoutHit = goSleep & (state_reg == BWPF_BUS_AWAKE);

    ////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states
    wire logic apbWr = psel & penable & pwrite;
    wire logic apbRd = psel & ~penable & ~pwrite;
    wire logic hitCtrl  = (paddr == `BWPF_OFF_CTRL);
    wire logic hitIdV   = (paddr == `BWPF_OFF_ID_VALUE);
    wire logic hitIdM   = (paddr == `BWPF_OFF_ID_MASK);
    wire logic hitDLo   = (paddr == `BWPF_OFF_DATA_LO);
    wire logic hitDHi   = (paddr == `BWPF_OFF_DATA_HI);
    wire logic hitMLo   = (paddr == `BWPF_OFF_MASK_LO);
    wire logic hitMHi   = (paddr == `BWPF_OFF_MASK_HI);
    wire logic hitTo    = (paddr == `BWPF_OFF_TIMEOUT);
    wire logic hitSt    = (paddr == `BWPF_OFF_STATUS);
    wire logic hitEv    = (paddr == `BWPF_OFF_EVCOUNT);
    wire logic mapped   = hitCtrl | hitIdV | hitIdM | hitDLo | hitDHi
                        | hitMLo | hitMHi | hitTo | hitSt | hitEv;
    wire logic ackWrite = apbWr & hitCtrl & pwdata[`BWPF_CTRL_ACK];
    wire logic [31:0] statusWord = {27'h000_0000, payOk_reg,
                                    (state_reg == BWPF_BUS_AWAKE),
                                    ignSync_reg, alert_reg,
                                    (state_reg != BWPF_ASLEEP)};
    wire logic [31:0] rdMux =
        hitCtrl ? {30'h0000_0000, ctrl_reg[1:0]} :
        hitIdV  ? idValue_reg :
        hitIdM  ? idMask_reg :
        hitDLo  ? dataValue_reg[31:0] :
        hitDHi  ? dataValue_reg[63:32] :
        hitMLo  ? dataMask_reg[31:0] :
        hitMHi  ? dataMask_reg[63:32] :
        hitTo   ? timeout_reg :
        hitSt   ? statusWord :
        hitEv   ? evCount_reg : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Sequential logic
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_reg <= `BWPF_WORD_RST;
        end else if (apbWr && hitCtrl) begin
            // Acknowledge bit acts once and is not stored
            ctrl_reg <= {30'h0000_0000, pwdata[1:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            idValue_reg <= `BWPF_WORD_RST;
        end else if (apbWr && hitIdV) begin
            idValue_reg <= pwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            idMask_reg <= `BWPF_WORD_RST;
        end else if (apbWr && hitIdM) begin
            idMask_reg <= pwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            dataValue_reg <= {`BWPF_WORD_RST, `BWPF_WORD_RST};
        end else if (apbWr) begin
            if (hitDLo) begin
                dataValue_reg[31:0] <= pwdata;
            end
            if (hitDHi) begin
                dataValue_reg[63:32] <= pwdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            dataMask_reg <= {`BWPF_WORD_RST, `BWPF_WORD_RST};
        end else if (apbWr) begin
            if (hitMLo) begin
                dataMask_reg[31:0] <= pwdata;
            end
            if (hitMHi) begin
                dataMask_reg[63:32] <= pwdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            timeout_reg <= `BWPF_TIMEOUT_RST;
        end else if (apbWr && hitTo) begin
            timeout_reg <= pwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ignMeta_reg <= 1'b0;
            ignSync_reg <= 1'b0;
        end else begin
            ignMeta_reg <= ignition;
            ignSync_reg <= ignMeta_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= BWPF_ASLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            idleCount_reg <= `BWPF_WORD_RST;
        end else begin
            idleCount_reg <= match ? `BWPF_WORD_RST : idleInc;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            payOk_reg <= 1'b0;
        end else if (rxValid) begin
            payOk_reg <= payOk;
        end
    end

    // Alert set wins over the software acknowledge
    always_ff @(posedge clock) begin
        if (!nrst) begin
            alert_reg <= 1'b0;
        end else begin
            alert_reg <= timeoutHit | (alert_reg & ~ackWrite);
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            evCount_reg <= `BWPF_WORD_RST;
        end else if (timeoutHit) begin
            evCount_reg <= evCount_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wakePulse    <= 1'b0;
            loggerRun    <= 1'b0;
            stopRequest  <= 1'b0;
            timeoutAlert <= 1'b0;
            logEntry     <= 1'b0;
        end else begin
            wakePulse    <= match;
            loggerRun    <= (state_next != BWPF_ASLEEP);
            stopRequest  <= goSleep;
            timeoutAlert <= timeoutHit | (alert_reg & ~ackWrite);
            logEntry     <= timeoutHit;
        end
    end

    // Answer in the access cycle; pready pulses for one cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // Read data stands until the next read
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (apbRd) begin
            prdata <= rdMux;
        end
    end
endmodule
`default_nettype wire

// *** hdl/bwpf_pkg.sv ***
// Types for the bus wake payload filter
package bwpf_pkg;
    typedef enum logic [1:0] {
        BWPF_ASLEEP,
        BWPF_BUS_AWAKE,
        BWPF_IGN_AWAKE
    } bwpf_state_e;
    typedef logic [63:0] bwpf_payload_t;
    typedef logic [28:0] bwpf_ident_t;
endpackage

// *** hdl/bwpf_regs.svh ***
// Register offsets, field positions and reset values
`ifndef BWPF_REGS_SVH
`define BWPF_REGS_SVH
`define BWPF_OFF_CTRL      12'h000
`define BWPF_OFF_ID_VALUE  12'h004
`define BWPF_OFF_ID_MASK   12'h008
`define BWPF_OFF_DATA_LO   12'h00C
`define BWPF_OFF_DATA_HI   12'h010
`define BWPF_OFF_MASK_LO   12'h014
`define BWPF_OFF_MASK_HI   12'h018
`define BWPF_OFF_TIMEOUT   12'h01C
`define BWPF_OFF_STATUS    12'h020
`define BWPF_OFF_EVCOUNT   12'h024
`define BWPF_CTRL_ENABLE   0
`define BWPF_CTRL_EXT      1
`define BWPF_CTRL_ACK      2
`define BWPF_ST_AWAKE      0
`define BWPF_ST_ALERT      1
`define BWPF_ST_IGN        2
`define BWPF_ST_BUSWAKE    3
`define BWPF_ST_PAYOK      4
`define BWPF_TIMEOUT_RST   32'h0000_0000
`define BWPF_WORD_RST      32'h0000_0000
`endif
